// *** hdl/sdmr_mode_regs.sv ***
// Mode and extended mode register programming logic
//
// Operation
// - All strobes and both bank bits low write the main register from A13..A0.
// - Main A2..A0 give the burst length for every column access.
// - Main A3 picks interleaved or sequential order, for bursts 4 and 8.
// - Main A6..A4 hold read latency, command to first data.
// - Main A11..A9 hold write recovery cycles for auto-precharge writes.
// - Bank bit 0 high, bit 1 low with strobes low writes extended register 1.
// - Extended 1 holds DLL, half drive, posted latency, termination, calibration, strobes.
// - DLL turns off on self refresh entry and on again at exit.
// - A11 turns mask into read strobe; A10 floats complement strobes.
// - Bank bit 1 high, bit 0 low with strobes low writes extended register 2.
// - Extended 2 A7 selects fast self refresh above 85 degrees.
// - Calibration field: exit, drive high, drive low, adjust, default.
// - Adjust codes step pull-up and pull-down by one, saturating in 16 steps.
// - Termination bits A6,A2: 01 is 75, 10 is 150, 11 is 50 ohms.
`timescale 1ns/1ps
module sdmr_mode_regs
   import sdmr_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic linkClk,
   input wire logic cke,
   input wire logic csN,
   input wire logic rasN,
   input wire logic casN,
   input wire logic weN,
   input wire logic [2:0] bankAddr,
   input wire logic [13:0] addr,
   input wire logic [7:0] dqIn,
   output logic [13:0] mainModeConfig,
   output logic [13:0] extendedModeConfigOne,
   output logic [13:0] extendedModeConfigTwo,
   output logic [13:0] extendedModeConfigThree,
   output logic dllOn,
   output logic inSelfRefresh,
   output logic [7:0] termOhms,
   output logic maskIsReadStrobe,
   output logic strobeCompOn,
   output logic readStrobeCompOn,
   output logic [7:0] dqOut,
   output logic dqOe,
   output logic dqsOut,
   output logic dqsCompOut,
   output logic dqsOe,
   output logic [3:0] pullUpStep,
   output logic [3:0] pullDownStep
);
   logic [PIN_W-1:0] pinSync;
   logic ckS, ckeS, csS, rasS, casS, weS, ckPrev, ckePrev;
   logic [2:0] baS;
   logic [13:0] addrS;
   logic [7:0] dqS;

   sdmr_sync #(.WIDTH(PIN_W)) u_sync (
      .clk(clk),
      .arst_n(arst_n),
      .async({linkClk, cke, csN, rasN, casN, weN, bankAddr, addr, dqIn}),
      .synced(pinSync)
   );
   assign {ckS, ckeS, csS, rasS, casS, weS, baS, addrS, dqS} = pinSync;

   // Command decode at link clock rising edge
   wire linkRise = ckS & ~ckPrev;
   wire modeCmd = linkRise & ckeS & ~csS & ~rasS & ~casS & ~weS;
   wire srEntry = linkRise & ckePrev & ~ckeS & ~csS & ~rasS & ~casS & weS;
   wire srExit = linkRise & inSelfRefresh & ~ckePrev & ckeS;
   wire writeCmd = linkRise & ckeS & ~csS & rasS & ~casS & ~weS;

   // Pending register write
   logic pendBusy;
   logic [1:0] pendSel;
   logic [13:0] pendVal;
   logic [2:0] pendCnt;
   wire applyNow = pendBusy & linkRise & (pendCnt == 3'h1);
   wire [2:0] newCal = pendVal[CAL_LSB +: 3];
   wire ext1Apply = applyNow & (pendSel == SEL_EXT1);

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ckPrev <= 1'b0;
         ckePrev <= 1'b0;
      end else begin
         ckPrev <= ckS;
         if (linkRise) begin
            ckePrev <= ckeS;
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pendBusy <= 1'b0;
         pendSel <= SEL_MAIN;
         pendVal <= REG_RESET;
         pendCnt <= 3'h0;
      end else if (modeCmd) begin
         pendBusy <= 1'b1;
         pendSel <= baS[1:0];
         pendVal <= addrS;
         pendCnt <= MODE_WRITE_TCK;
      end else if (pendBusy & linkRise) begin
         pendCnt <= pendCnt - 3'h1;
         pendBusy <= (pendCnt != 3'h1);
      end
   end

   // Register store, selected by the bank bits
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         mainModeConfig <= REG_RESET;
         extendedModeConfigOne <= REG_RESET;
         extendedModeConfigTwo <= REG_RESET;
         extendedModeConfigThree <= REG_RESET;
      end else if (applyNow) begin
         case (pendSel)
            SEL_MAIN: mainModeConfig <= pendVal;
            SEL_EXT1: extendedModeConfigOne <= pendVal;
            SEL_EXT2: extendedModeConfigTwo <= pendVal;
            SEL_EXT3: extendedModeConfigThree <= pendVal;
            default: mainModeConfig <= mainModeConfig;
         endcase
      end
   end

   // Self refresh tracking and DLL state
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         inSelfRefresh <= 1'b0;
      end else if (srEntry) begin
         inSelfRefresh <= 1'b1;
      end else if (srExit) begin
         inSelfRefresh <= 1'b0;
      end
   end

   wire dllReq = ~extendedModeConfigOne[DLL_DIS_BIT] & ~inSelfRefresh;

   // Termination and strobe configuration
   wire [1:0] rttSel = {extendedModeConfigOne[RTT_HI_BIT], extendedModeConfigOne[RTT_LO_BIT]};
   wire [7:0] rttDecode = (rttSel == 2'h1) ? RTT_75 :
                          (rttSel == 2'h2) ? RTT_150 :
                          (rttSel == 2'h3) ? RTT_50 : RTT_OFF;
   wire readStrobeEn = extendedModeConfigOne[RSTROBE_BIT];
   wire compDis = extendedModeConfigOne[COMP_DIS_BIT];

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         dllOn <= 1'b0;
         termOhms <= RTT_OFF;
         maskIsReadStrobe <= 1'b0;
         strobeCompOn <= 1'b0;
         readStrobeCompOn <= 1'b0;
      end else begin
         dllOn <= dllReq;
         termOhms <= rttDecode;
         maskIsReadStrobe <= readStrobeEn;
         strobeCompOn <= ~compDis;
         readStrobeCompOn <= readStrobeEn & ~compDis;
      end
   end

   // Calibration drive modes
   wire [2:0] calField = extendedModeConfigOne[CAL_LSB +: 3];
   wire driveHi = (calField == CAL_DRIVE_HI);
   wire driveLo = (calField == CAL_DRIVE_LO);

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         dqOut <= 8'h00;
         dqOe <= 1'b0;
         dqsOut <= 1'b0;
         dqsCompOut <= 1'b0;
         dqsOe <= 1'b0;
      end else begin
         dqOut <= {8{driveHi}};
         dqOe <= driveHi | driveLo;
         dqsOut <= driveHi;
         dqsCompOut <= driveLo;
         dqsOe <= driveHi | driveLo;
      end
   end

   // Adjust mode: collect four code beats after a write command
   sdmr_cal_t calState;
   logic [2:0] beatCnt;
   logic [3:0] adjCode;
   wire [3:0] next_adjCode = {adjCode[2:0], dqS[0]};
   wire beatLast = (calState == CAL_BEATS) & linkRise & (beatCnt == 3'h1);
   wire codeOk = ~(next_adjCode[3] & next_adjCode[2]) & ~(next_adjCode[1] & next_adjCode[0]);
   wire upInc = beatLast & codeOk & next_adjCode[0];
   wire upDec = beatLast & codeOk & next_adjCode[1];
   wire dnInc = beatLast & codeOk & next_adjCode[2];
   wire dnDec = beatLast & codeOk & next_adjCode[3];
   wire calDefault = ext1Apply & (newCal == CAL_DEFAULT);

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         calState <= CAL_IDLE;
         beatCnt <= 3'h0;
         adjCode <= 4'h0;
      end else begin
         case (calState)
            CAL_IDLE: begin
               if (calField == CAL_ADJUST) begin
                  calState <= CAL_WAIT_WR;
               end
            end
            CAL_WAIT_WR: begin
               if (calField != CAL_ADJUST) begin
                  calState <= CAL_IDLE;
               end else if (writeCmd) begin
                  calState <= CAL_BEATS;
                  beatCnt <= ADJ_BEATS;
               end
            end
            CAL_BEATS: begin
               if (linkRise) begin
                  adjCode <= next_adjCode;
                  beatCnt <= beatCnt - 3'h1;
                  if (beatCnt == 3'h1) begin
                     calState <= CAL_WAIT_WR;
                  end
               end
            end
            default: calState <= CAL_IDLE;
         endcase
      end
   end

   // Saturating driver strength steps
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pullUpStep <= STEP_DEFAULT;
         pullDownStep <= STEP_DEFAULT;
      end else if (calDefault) begin
         pullUpStep <= STEP_DEFAULT;
         pullDownStep <= STEP_DEFAULT;
      end else begin
         if (upInc && pullUpStep != STEP_MAX) begin
            pullUpStep <= pullUpStep + 4'h1;
         end else if (upDec && pullUpStep != STEP_MIN) begin
            pullUpStep <= pullUpStep - 4'h1;
         end
         if (dnInc && pullDownStep != STEP_MAX) begin
            pullDownStep <= pullDownStep + 4'h1;
         end else if (dnDec && pullDownStep != STEP_MIN) begin
            pullDownStep <= pullDownStep - 4'h1;
         end
      end
   end
   // Checks
   sequence s_modeCmdTaken;
      modeCmd ##1 pendBusy;
   endsequence
   a_write_takes_pending: assert property (@(posedge clk) disable iff (!arst_n)
      modeCmd |-> ##1 (pendBusy && pendVal == $past(addrS) && pendSel == $past(baS[1:0])))
      else $error("mode write not latched");
   a_write_delayed_apply: assert property (@(posedge clk) disable iff (!arst_n)
      s_modeCmdTaken |-> !applyNow) else $error("write applied too early");
   a_main_reg_update: assert property (@(posedge clk) disable iff (!arst_n)
      (applyNow && pendSel == SEL_MAIN) |=> mainModeConfig == $past(pendVal))
      else $error("main register not updated");
   a_ext1_reg_update: assert property (@(posedge clk) disable iff (!arst_n)
      (applyNow && pendSel == SEL_EXT1) |=> extendedModeConfigOne == $past(pendVal))
      else $error("extended register one not updated");
   a_ext2_reg_update: assert property (@(posedge clk) disable iff (!arst_n)
      (applyNow && pendSel == SEL_EXT2) |=> extendedModeConfigTwo == $past(pendVal))
      else $error("extended register two not updated");
   a_dll_self_refresh: assert property (@(posedge clk) disable iff (!arst_n)
      srEntry |-> ##2 !dllOn) else $error("DLL still on in self refresh");
   a_term_decode: assert property (@(posedge clk) disable iff (!arst_n)
      ##1 (termOhms == ($past(rttSel) == 2'h1 ? RTT_75 : $past(rttSel) == 2'h2 ? RTT_150 :
                        $past(rttSel) == 2'h3 ? RTT_50 : RTT_OFF)))
      else $error("termination decode wrong");
   a_drive_high_mode: assert property (@(posedge clk) disable iff (!arst_n)
      driveHi |=> (dqOe && dqOut == 8'hff && dqsOut && !dqsCompOut))
      else $error("drive high outputs wrong");
   a_strobe_config: assert property (@(posedge clk) disable iff (!arst_n)
      (readStrobeEn && !compDis) |=> (maskIsReadStrobe && readStrobeCompOn && strobeCompOn))
      else $error("strobe configuration wrong");
   a_step_saturate: assert property (@(posedge clk) disable iff (!arst_n)
      (upInc && !calDefault && pullUpStep == STEP_MAX) |=> pullUpStep == STEP_MAX)
      else $error("pull-up step wrapped");
endmodule

// *** hdl/sdmr_pkg.sv ***
// Constants for the mode register programming block
package sdmr_pkg;
   localparam int PIN_W = 31;
   localparam int ADDR_W = 14;
   // Mode write cycle time in link clock cycles
   localparam logic [2:0] MODE_WRITE_TCK = 3'h2;
   // Bank select codes
   localparam logic [1:0] SEL_MAIN = 2'h0;
   localparam logic [1:0] SEL_EXT1 = 2'h1;
   localparam logic [1:0] SEL_EXT2 = 2'h2;
   localparam logic [1:0] SEL_EXT3 = 2'h3;
   // Main register fields
   localparam int BL_LSB = 0;
   localparam int ORDER_BIT = 3;
   localparam int RL_LSB = 4;
   localparam int TEST_BIT = 7;
   localparam int DLLRST_BIT = 8;
   localparam int WR_LSB = 9;
   // Extended register 1 fields
   localparam int DLL_DIS_BIT = 0;
   localparam int HALF_BIT = 1;
   localparam int RTT_LO_BIT = 2;
   localparam int PL_LSB = 3;
   localparam int RTT_HI_BIT = 6;
   localparam int CAL_LSB = 7;
   localparam int COMP_DIS_BIT = 10;
   localparam int RSTROBE_BIT = 11;
   // Extended register 2 fields
   localparam int DCC_BIT = 3;
   localparam int HITEMP_BIT = 7;
   // Calibration field codes
   localparam logic [2:0] CAL_EXIT = 3'h0;
   localparam logic [2:0] CAL_DRIVE_HI = 3'h1;
   localparam logic [2:0] CAL_DRIVE_LO = 3'h2;
   localparam logic [2:0] CAL_ADJUST = 3'h4;
   localparam logic [2:0] CAL_DEFAULT = 3'h7;
   // Termination nominal values in ohms
   localparam logic [7:0] RTT_OFF = 8'h00;
   localparam logic [7:0] RTT_75 = 8'h4b;
   localparam logic [7:0] RTT_150 = 8'h96;
   localparam logic [7:0] RTT_50 = 8'h32;
   // Driver strength steps
   localparam logic [3:0] STEP_MAX = 4'hf;
   localparam logic [3:0] STEP_MIN = 4'h0;
   localparam logic [3:0] STEP_DEFAULT = 4'h8;
   localparam logic [2:0] ADJ_BEATS = 3'h4;
   localparam logic [13:0] REG_RESET = 14'h0000;
   typedef enum logic [1:0] {CAL_IDLE, CAL_WAIT_WR, CAL_BEATS} sdmr_cal_t;
endpackage

// *** hdl/sdmr_sync.sv ***
// Two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module sdmr_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [WIDTH-1:0] async,
   output logic [WIDTH-1:0] synced
);
   logic [WIDTH-1:0] stage;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         stage <= '0;
         synced <= '0;
      end else begin
         stage <= async;
         synced <= stage;
      end
   end
endmodule

// *** test/sdmr_ctrl_model.sv ***
// Memory controller model driving the link clock and command pins
`timescale 1ns/1ps
module sdmr_ctrl_model
   import sdmr_pkg::*;
(
   input wire logic clk,
   output logic linkClk,
   output logic cke,
   output logic csN,
   output logic rasN,
   output logic casN,
   output logic weN,
   output logic [2:0] bankAddr,
   output logic [13:0] addr,
   output logic [7:0] dqIn
);
   logic [3:0] ph = 4'h0;
   initial begin
      {cke, csN, rasN, casN, weN} = 5'h1f;
      bankAddr = 3'h0;
      addr = 14'h0000;
      dqIn = 8'h00;
   end
   // Free running link clock, 16 system clocks a period
   always @(posedge clk) begin
      ph <= ph + 4'h1;
      linkClk <= ph >= 4'h7;
   end
   // One link cycle; pins held well around the rise
   task automatic slot(input logic [3:0] c, input logic [2:0] ba, input logic [13:0] a,
         input logic ck, input logic d);
      @(posedge clk iff ph == 4'h2);
      {csN, rasN, casN, weN} <= c;
      bankAddr <= ba;
      addr <= a;
      cke <= ck;
      dqIn <= {8{d}};
   endtask
   // Idle cycles; released pins show the inverse of the last value
   task automatic nop(input int n);
      repeat (n) slot(4'b0111, ~bankAddr, ~addr, cke, ~dqIn[0]);
   endtask
   task automatic mode_write(input logic [1:0] sel, input logic [13:0] a);
      slot(4'b0000, {1'b0, sel}, a, 1'b1, 1'b0);
      nop(3);
   endtask
   // Adjust entry, code burst T0 first, then calibration exit
   task automatic adjust(input logic [13:0] e1, input logic [3:0] c);
      mode_write(SEL_EXT1, e1 | 14'h0200);
      slot(4'b0100, 3'h0, 14'h0000, 1'b1, 1'b0);
      for (int i = 3; i >= 0; i--) slot(4'b0111, 3'h0, 14'h0000, 1'b1, c[i]);
      mode_write(SEL_EXT1, e1);
   endtask
endmodule

// *** test/sdmr_mode_register_programming_bench.sv ***
// Self-checking bench for the mode register programming block
`timescale 1ns/1ps
module sdmr_mode_register_programming_bench
   import sdmr_pkg::*;
();
   logic clk;
   logic arst_n;
   logic linkClk, cke, csN, rasN, casN, weN;
   logic [2:0] bankAddr;
   logic [13:0] addr;
   logic [7:0] dqIn;
   logic [13:0] mainModeConfig, extendedModeConfigOne, extendedModeConfigTwo;
   logic [13:0] extendedModeConfigThree, e1;
   logic dllOn, inSelfRefresh, maskIsReadStrobe, strobeCompOn, readStrobeCompOn;
   logic [7:0] termOhms, dqOut;
   logic dqOe, dqsOut, dqsCompOut, dqsOe, d;
   logic [3:0] pullUpStep, pullDownStep, eu, ed, code, sb;
   logic [2:0] cal;
   logic [11:0] pins;
   int n_mismatch = 0;
   int cmp_count = 0;
   localparam logic [13:0] MAIN_A = 14'h0632;
   localparam logic [13:0] MAIN_B = 14'h0a42;
   localparam logic [13:0] EXT1 = 14'h0010;
   logic [13:0] vals [4] = '{MAIN_A, EXT1, 14'h0088, 14'h0000};
   logic [3:0] adjTbl [11] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h5, 4'h6, 4'h9, 4'ha, 4'hc, 4'h3, 4'h0};
   logic [7:0] ohmTbl [4] = '{RTT_OFF, RTT_75, RTT_150, RTT_50};

   sdmr_ctrl_model ctl (.clk, .linkClk, .cke, .csN, .rasN, .casN, .weN, .bankAddr, .addr, .dqIn);
   sdmr_mode_regs DUT (.clk, .arst_n, .linkClk, .cke, .csN, .rasN, .casN, .weN, .bankAddr,
      .addr, .dqIn, .mainModeConfig, .extendedModeConfigOne, .extendedModeConfigTwo,
      .extendedModeConfigThree, .dllOn, .inSelfRefresh, .termOhms, .maskIsReadStrobe,
      .strobeCompOn, .readStrobeCompOn, .dqOut, .dqOe, .dqsOut, .dqsCompOut, .dqsOe,
      .pullUpStep, .pullDownStep);

   task automatic check(input string what, input logic [13:0] exp, input logic [13:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   function automatic logic [3:0] stepv(input logic [3:0] v, input logic up, input logic dn);
      if (up && v != STEP_MAX) return v + 4'h1;
      if (dn && v != STEP_MIN) return v - 4'h1;
      return v;
   endfunction
   task automatic close_out();
      $display("Comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      #200000;
      n_mismatch++;
      $display("MISMATCH watchdog expected end seen hang");
      close_out();
   end

   initial begin
      arst_n = 1'b0;
      repeat (5) @(posedge clk);
      arst_n <= 1'b1;
      repeat (4) @(posedge clk);
      check("main", REG_RESET, mainModeConfig);
      check("ext1", REG_RESET, extendedModeConfigOne);
      check("steps", {6'h00, STEP_DEFAULT, STEP_DEFAULT}, {6'h00, pullUpStep, pullDownStep});
      $display("test reset done");
      for (int s = 0; s < 4; s++) ctl.mode_write(2'(s), vals[s]);
      check("main", MAIN_A, mainModeConfig);
      check("ext1", EXT1, extendedModeConfigOne);
      check("ext2", vals[2], extendedModeConfigTwo);
      check("ext3", vals[3], extendedModeConfigThree);
      ctl.mode_write(SEL_MAIN, MAIN_A | 14'h0100);
      check("main dll reset", MAIN_A | 14'h0100, mainModeConfig);
      ctl.nop(200);
      ctl.mode_write(SEL_MAIN, MAIN_A);
      check("main rewrite", MAIN_A, mainModeConfig);
      $display("test select done");
      ctl.slot(4'b0000, 3'h0, MAIN_B, 1'b1, 1'b0);
      ctl.nop(2);
      check("main early", MAIN_A, mainModeConfig);
      ctl.nop(1);
      check("main late", MAIN_B, mainModeConfig);
      for (int k = 0; k < 3; k++) begin
         code = k == 0 ? 4'b0011 : (k == 1 ? 4'b0001 : 4'b0100);
         ctl.slot(code, 3'h0, 14'h1fff, 1'b1, 1'b1);
         ctl.nop(3);
      end
      check("main kept", MAIN_B, mainModeConfig);
      check("steps kept", {6'h00, 8'h88}, {6'h00, pullUpStep, pullDownStep});
      $display("test timing done");
      for (int i = 0; i < 4; i++) begin
         e1 = EXT1 | {2'h0, i[1], i[0], 3'h0, i[1], 3'h0, i[0], 1'b0, i[0]};
         ctl.mode_write(SEL_EXT1, e1);
         check("term", {6'h00, ohmTbl[i]}, {6'h00, termOhms});
         sb = {maskIsReadStrobe, strobeCompOn, readStrobeCompOn, dllOn};
         check("strobes", {10'h000, i[1], ~i[0], i[1] & ~i[0], ~i[0]}, {10'h000, sb});
      end
      $display("test term done");
      ctl.mode_write(SEL_EXT1, EXT1);
      ctl.slot(4'b0001, 3'h0, 14'h0000, 1'b0, 1'b0);
      ctl.nop(1);
      check("sref in", 14'h0002, {12'h000, inSelfRefresh, dllOn});
      ctl.slot(4'b0111, 3'h0, 14'h0000, 1'b1, 1'b0);
      ctl.nop(1);
      check("sref out", 14'h0001, {12'h000, inSelfRefresh, dllOn});
      $display("test sref done");
      for (int i = 0; i < 2; i++) begin
         cal = i == 0 ? CAL_DRIVE_HI : CAL_DRIVE_LO;
         d = (i == 0);
         ctl.mode_write(SEL_EXT1, EXT1 | {4'h0, cal, 7'h00});
         pins = {dqOut, dqOe, dqsOut, dqsCompOut, dqsOe};
         check("drive", {2'h0, {8{d}}, 1'b1, d, ~d, 1'b1}, {2'h0, pins});
         ctl.mode_write(SEL_EXT1, EXT1);
         check("release", 14'h0000, {12'h000, dqOe, dqsOe});
      end
      $display("test drive done");
      eu = STEP_DEFAULT;
      ed = STEP_DEFAULT;
      for (int k = 0; k < 35; k++) begin
         code = k < 11 ? adjTbl[k] : (k < 19 ? 4'h5 : 4'ha);
         if (!((code[3] & code[2]) | (code[1] & code[0]))) begin
            eu = stepv(eu, code[0], code[1]);
            ed = stepv(ed, code[2], code[3]);
         end
         ctl.adjust(EXT1, code);
         check("adjust", {6'h00, eu, ed}, {6'h00, pullUpStep, pullDownStep});
      end
      ctl.mode_write(SEL_EXT1, EXT1 | 14'h0380);
      ctl.mode_write(SEL_EXT1, EXT1);
      check("default", {6'h00, STEP_DEFAULT, STEP_DEFAULT}, {6'h00, pullUpStep, pullDownStep});
      $display("test adjust done");
      close_out();
   end
endmodule
